// *** hw/fsq_defines.vh ***
// Purpose: Shared constants of the floppy microsequencer core
// Assumes: Included by bare name from every design file
// Notes:   Timing counts derive from the clock and oscillator rates
`ifndef FSQ_DEFINES_VH
`define FSQ_DEFINES_VH

// ----------------------------------------------------------------
// Microcode store
// ----------------------------------------------------------------
`define FSQ_ROM_WORDS 1536
`define FSQ_FIELD_WORDS 256
`define FSQ_FIELD_COUNT 6
`define FSQ_ROM_ADDR_W 11

// ----------------------------------------------------------------
// Instruction fields and type codes
// ----------------------------------------------------------------
`define FSQ_INST_MSB 7
`define FSQ_INST_LSB 6
`define FSQ_SEL_MSB 5
`define FSQ_SEL_LSB 2
`define FSQ_CTL_HIGH 1
`define FSQ_CTL_LOW 0
`define FSQ_OP_ACTION 2'h0
`define FSQ_OP_BRANCH 2'h1
`define FSQ_OP_WAIT 2'h2
`define FSQ_OP_SCRATCH_JUMP 2'h3

// ----------------------------------------------------------------
// Action strobes steering internal logic
// ----------------------------------------------------------------
`define FSQ_STB_LOOP_CNT 4'h1
`define FSQ_STB_SHIFTER 4'h2
`define FSQ_STB_SCRATCH_WR 4'h3
`define FSQ_STB_BUF_WRITE 4'h4
`define FSQ_STB_BUF_ADDR 4'h5

// ----------------------------------------------------------------
// Branch condition slots driven internally
// ----------------------------------------------------------------
`define FSQ_CND_TOP_BIT 4'h0
`define FSQ_CND_TOP_XOR 4'h1
`define FSQ_CND_LOOP_FULL 4'h2
`define FSQ_CND_BUF_WRAP 4'h3
`define FSQ_CND_BUF_OUT 4'h4

// ----------------------------------------------------------------
// Sector buffer
// ----------------------------------------------------------------
`define FSQ_BUF_BITS 1024
`define FSQ_BUF_ADDR_W 12

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSQ_SYS_CLK_MHZ 250
`define FSQ_OSC_MHZ 20
`define FSQ_INSTR_NS 200
`define FSQ_PHASE_NS 50
`define FSQ_RING_RESET 4'h1
`define FSQ_PC_RESET 8'h00

`endif

// *** hw/fsq_timing_ring.v ***
// Purpose: Four-phase timing ring stepped at the oscillator rate
// Assumes: System clock faster than the oscillator rate
// Notes:   Oscillator steps come from a fractional accumulator
`include "fsq_defines.vh"

module fsq_timing_ring #(
    parameter [7:0] OSC_STEP = `FSQ_OSC_MHZ,
    parameter [7:0] SYS_MOD = `FSQ_SYS_CLK_MHZ
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_restart,
    output reg o_timing_phase_three,
    output reg o_timing_phase_four,
    output reg o_exec_start,
    output reg o_fetch_start
);

    reg [7:0] acc_reg;
    reg [3:0] ring_reg;
    wire [8:0] acc_sum = {1'b0, acc_reg} + {1'b0, OSC_STEP};
    wire step = (acc_sum >= {1'b0, SYS_MOD});
    wire [7:0] acc_next = step ? acc_sum[7:0] - SYS_MOD : acc_sum[7:0];
    wire ring_ok = (ring_reg == 4'h1) || (ring_reg == 4'h2) || (ring_reg == 4'h4) || (ring_reg == 4'h8);
    wire [3:0] ring_next = ring_ok ? {ring_reg[2:0], ring_reg[3]} : `FSQ_RING_RESET;

    // ------------------------------------------------------------
    // Ring with one recirculating bit; bit 2 then bit 3
    // ------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            acc_reg <= 8'h00;
            ring_reg <= `FSQ_RING_RESET;
            o_timing_phase_three <= 1'b0;
            o_timing_phase_four <= 1'b0;
            o_exec_start <= 1'b0;
            o_fetch_start <= 1'b0;
        end else if (i_restart) begin
            acc_reg <= 8'h00; // see [RULE24]
            ring_reg <= `FSQ_RING_RESET; // see [RULE24]
            o_timing_phase_three <= 1'b0;
            o_timing_phase_four <= 1'b0;
            o_exec_start <= 1'b0;
            o_fetch_start <= 1'b0;
        end else begin
            acc_reg <= acc_next; // see [RULE17]
            if (step) begin
                ring_reg <= ring_next; // see [RULE17]
            end
            o_timing_phase_three <= step ? ring_next[2] : ring_reg[2]; // see [RULE17]
            o_timing_phase_four <= step ? ring_next[3] : ring_reg[3]; // see [RULE17]
            o_exec_start <= step && ring_next[2]; // see [RULE25]
            o_fetch_start <= step && ring_next[3]; // see [RULE25]
        end
    end

endmodule // fsq_timing_ring

// *** hw/fsq_sequencer_core.v ***
// Purpose: Microprogrammed sequencer core of a floppy disk controller
// Assumes: 250 MHz system clock; pins are asynchronous to it
// Notes:   One instruction executes in phase three, the next is fetched in phase four
// Operation
// [RULE1] Microprogram store holds 1536 eight-bit words driving all control.
// [RULE2] Store split in six 256-word fields; eight-bit counter addresses within field.
// [RULE3] Program counter advances or reloads once every 200 ns; the code also steps or reloads it in phase three for branches, waits and jumps.
// [RULE4] Bits 7:6 type, bits 5:2 select, bits 1:0 control.
// [RULE5] Fetch strobe loads addressed word into the instruction buffer.
// [RULE6] Action instruction pulses one of sixteen strobes in phase three.
// [RULE7] Branch compares selected condition with high control bit; load or increment.
// [RULE8] Condition selector enabled during every branch; outputs increment or load; a wait branch not taken decrements instead.
// [RULE9] Wait branch always pulses the loop counter clock.
// [RULE10] Open scratch pad latches select field into scratch address.
// [RULE11] Sixteen-word scratch pad written from shifter on strobe, read otherwise.
// [RULE12] Input selector: scratch data when low control bit set, store otherwise.
// [RULE13] Jump or taken branch loads counter from next word or scratch pad.
// [RULE14] Loop counter loads when high bit clear, else increments; all-ones flags.
// [RULE15] Shifter: 00 zero, 01 load counter, 10 one, 11 disk bit.
// [RULE16] Conditions: shifter top bit, and top bit xor disk bit xor missing clock.
// [RULE17] Two 50 ns phases at 5 MHz from a 20 MHz ring.
// [RULE18] Load clears low ten address bits; otherwise count once per bit.
// [RULE19] Top address bits load inverted low control bit; wrap after 4096 or 1024.
// [RULE20] Buffer write enable set by strobe with low bit, cleared without it.
// [RULE21] Buffer stores disk bit or interface bit; reads out serially.
// [RULE22] Sector buffer is 1024 by one bit, addressed by address counter.
// [RULE23] Five instruction types: action, branch, wait branch, open scratch, jump.
// [RULE24] Init clears the program counter and restarts the timing ring.
// [RULE25] All sequencer updates are gated by the derived timing phases; o_buffer_serial_out is reloaded on every system clock.
`include "fsq_defines.vh"

module fsq_sequencer_core #(
    parameter ROM_WORDS = `FSQ_ROM_WORDS,
    parameter BUF_BITS = `FSQ_BUF_BITS
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_sequencer_init,
    input wire [2:0] i_field_select,
    input wire [15:0] i_branch_cond,
    input wire i_separated_disk_bit,
    input wire i_missing_clock_flag,
    input wire i_interface_serial_data,
    input wire i_rom_load_en,
    input wire [10:0] i_rom_load_addr,
    input wire [7:0] i_rom_load_data,
    output wire o_timing_phase_three,
    output wire o_timing_phase_four,
    output reg [15:0] o_action_strobe,
    output reg o_fetch_load_strobe,
    output reg o_wait_branch_count_clock,
    output reg [7:0] o_program_counter,
    output reg [7:0] o_instruction,
    output reg [3:0] o_scratch_addr,
    output reg [7:0] o_loop_counter,
    output reg o_loop_counter_full,
    output reg [7:0] o_shifter,
    output reg [11:0] o_buffer_addr,
    output reg o_buffer_addr_wrap,
    output reg o_buffer_write_enable,
    output reg o_buffer_serial_out
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam SYNC_W = 23;
    wire [SYNC_W-1:0] pin_raw = {i_sequencer_init, i_field_select, i_branch_cond,
                                 i_separated_disk_bit, i_missing_clock_flag,
                                 i_interface_serial_data};
    reg [SYNC_W-1:0] sync1_reg;
    reg [SYNC_W-1:0] sync2_reg;

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
            always @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                end else begin
                    sync1_reg[g] <= pin_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                end
            end
        end
    endgenerate

    wire init_s = sync2_reg[22];
    wire [2:0] field_s = sync2_reg[21:19];
    wire [15:0] cond_s = sync2_reg[18:3];
    wire sep_bit_s = sync2_reg[2];
    wire missing_clock_flag_s = sync2_reg[1];
    wire if_data_s = sync2_reg[0];

    // ------------------------------------------------------------
    // Timing phases
    // ------------------------------------------------------------
    wire exec_start;
    wire fetch_start;

    fsq_timing_ring u_ring (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_restart(init_s),
        .o_timing_phase_three(o_timing_phase_three),
        .o_timing_phase_four(o_timing_phase_four),
        .o_exec_start(exec_start),
        .o_fetch_start(fetch_start)
    );

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function [15:0] fsq_onehot;
        input [3:0] sel;
        begin
            fsq_onehot = 16'h0001 << sel;
        end
    endfunction

    function fsq_pick;
        input [15:0] lines;
        input [3:0] sel;
        begin
            fsq_pick = lines[sel];
        end
    endfunction

    // ------------------------------------------------------------
    // Microcode store
    // ------------------------------------------------------------
    reg [7:0] rom_mem [0:ROM_WORDS-1];
    wire [10:0] rom_addr = {field_s, o_program_counter}; // see [RULE2]
    wire field_ok = (field_s < `FSQ_FIELD_COUNT);
    wire [7:0] rom_word = field_ok ? rom_mem[rom_addr] : 8'h00; // see [RULE1]

    always @(posedge i_sys_clk) begin
        if (i_rom_load_en && (i_rom_load_addr < ROM_WORDS)) begin
            rom_mem[i_rom_load_addr] <= i_rom_load_data; // see [RULE1]
        end
    end

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    reg mb_valid_reg;
    wire [1:0] op = o_instruction[`FSQ_INST_MSB:`FSQ_INST_LSB]; // see [RULE4]
    wire [3:0] sel = o_instruction[`FSQ_SEL_MSB:`FSQ_SEL_LSB]; // see [RULE4]
    wire ctl_high = o_instruction[`FSQ_CTL_HIGH]; // see [RULE4]
    wire ctl_low = o_instruction[`FSQ_CTL_LOW]; // see [RULE4]
    wire run = exec_start && mb_valid_reg; // see [RULE25]
    wire is_action = (op == `FSQ_OP_ACTION); // see [RULE23]
    wire is_branch = (op == `FSQ_OP_BRANCH); // see [RULE23]
    wire is_wait = (op == `FSQ_OP_WAIT); // see [RULE23]
    wire is_scratch = (op == `FSQ_OP_SCRATCH_JUMP) && !ctl_high; // see [RULE23]
    wire is_jump = (op == `FSQ_OP_SCRATCH_JUMP) && ctl_high; // see [RULE23]
    wire [15:0] strobes = (run && is_action) ? fsq_onehot(sel) : 16'h0000; // see [RULE6]

    // ------------------------------------------------------------
    // Scratch pad and input selector
    // ------------------------------------------------------------
    reg [7:0] scratch_mem [0:15];
    wire [7:0] scratch_data = scratch_mem[o_scratch_addr]; // see [RULE11]
    wire [7:0] in_select = ctl_low ? scratch_data : rom_word; // see [RULE12]
    wire scratch_write_strobe = strobes[`FSQ_STB_SCRATCH_WR];

    always @(posedge i_sys_clk) begin
        if (scratch_write_strobe) begin
            scratch_mem[o_scratch_addr] <= o_shifter; // see [RULE11]
        end
    end

    // ------------------------------------------------------------
    // Branch condition selector
    // ------------------------------------------------------------
    reg [15:0] cond_lines;
    always @* begin
        cond_lines = cond_s;
        cond_lines[`FSQ_CND_TOP_BIT] = o_shifter[7]; // see [RULE16]
        cond_lines[`FSQ_CND_TOP_XOR] = o_shifter[7] ^ sep_bit_s ^ missing_clock_flag_s; // see [RULE16]
        cond_lines[`FSQ_CND_LOOP_FULL] = o_loop_counter_full; // see [RULE14]
        cond_lines[`FSQ_CND_BUF_WRAP] = o_buffer_addr_wrap; // see [RULE19]
        cond_lines[`FSQ_CND_BUF_OUT] = o_buffer_serial_out;
    end

    wire branch_en = is_branch || is_wait; // see [RULE8]
    wire cond_match = branch_en && (fsq_pick(cond_lines, sel) == ctl_high); // see [RULE7]

    // ------------------------------------------------------------
    // Program counter and instruction buffer
    // ------------------------------------------------------------
    reg [7:0] pc_next;
    always @* begin
        pc_next = o_program_counter;
        if (run) begin
            if (is_jump || (branch_en && cond_match)) begin
                pc_next = in_select; // see [RULE13]
            end else if (is_branch) begin
                pc_next = o_program_counter + 8'h01; // see [RULE7]
            end else if (is_wait) begin
                pc_next = o_program_counter - 8'h01;
            end
        end else if (fetch_start) begin
            pc_next = o_program_counter + 8'h01; // see [RULE3]
        end
    end

    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_program_counter <= `FSQ_PC_RESET;
            o_instruction <= 8'h00;
            mb_valid_reg <= 1'b0;
            o_fetch_load_strobe <= 1'b0;
        end else if (init_s) begin
            o_program_counter <= `FSQ_PC_RESET; // see [RULE24]
            mb_valid_reg <= 1'b0;
            o_fetch_load_strobe <= 1'b0;
        end else begin
            o_program_counter <= pc_next; // see [RULE3]
            o_fetch_load_strobe <= fetch_start;
            if (fetch_start) begin
                o_instruction <= rom_word; // see [RULE5]
                mb_valid_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Strobe outputs and scratch address
    // ------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_action_strobe <= 16'h0000;
            o_wait_branch_count_clock <= 1'b0;
            o_scratch_addr <= 4'h0;
        end else begin
            if (run && is_action) begin
                o_action_strobe <= strobes; // see [RULE6]
            end else if (!o_timing_phase_three) begin
                o_action_strobe <= 16'h0000;
            end
            o_wait_branch_count_clock <= run && is_wait; // see [RULE9]
            if (run && is_scratch) begin
                o_scratch_addr <= sel; // see [RULE10]
            end
        end
    end

    // ------------------------------------------------------------
    // Loop counter
    // ------------------------------------------------------------
    wire loop_counter_clock = strobes[`FSQ_STB_LOOP_CNT] || (run && is_wait); // see [RULE9]
    wire [7:0] loop_next = ctl_high ? o_loop_counter + 8'h01 : in_select; // see [RULE14]

    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_loop_counter <= 8'h00;
            o_loop_counter_full <= 1'b0;
        end else if (loop_counter_clock) begin
            o_loop_counter <= loop_next; // see [RULE14]
            o_loop_counter_full <= (loop_next == 8'hFF); // see [RULE14]
        end
    end

    // ------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------
    wire shifter_clock = strobes[`FSQ_STB_SHIFTER];

    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_shifter <= 8'h00;
        end else if (shifter_clock) begin
            case ({ctl_high, ctl_low})
                2'h0: o_shifter <= {o_shifter[6:0], 1'b0}; // see [RULE15]
                2'h1: o_shifter <= o_loop_counter; // see [RULE15]
                2'h2: o_shifter <= {o_shifter[6:0], 1'b1}; // see [RULE15]
                2'h3: o_shifter <= {o_shifter[6:0], sep_bit_s}; // see [RULE15]
                default: o_shifter <= o_shifter;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sector buffer and address counter
    // ------------------------------------------------------------
    reg buf_mem [0:BUF_BITS-1];
    wire buf_write_strobe = strobes[`FSQ_STB_BUF_WRITE];
    wire buf_addr_clock = strobes[`FSQ_STB_BUF_ADDR];
    wire [9:0] buf_index = o_buffer_addr[9:0]; // see [RULE22]
    wire buf_wdata = ctl_high ? if_data_s : sep_bit_s; // see [RULE21]
    wire [12:0] addr_inc = {1'b0, o_buffer_addr} + 13'h0001;

    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_buffer_addr <= 12'h000;
            o_buffer_addr_wrap <= 1'b0;
        end else if (buf_addr_clock) begin
            if (!ctl_high) begin
                o_buffer_addr <= {~ctl_low, ~ctl_low, 10'h000}; // see [RULE18] [RULE19]
                o_buffer_addr_wrap <= 1'b0;
            end else begin
                o_buffer_addr <= addr_inc[11:0]; // see [RULE18]
                if (addr_inc[12]) begin
                    o_buffer_addr_wrap <= 1'b1; // see [RULE19]
                end
            end
        end
    end

    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_buffer_write_enable <= 1'b0;
        end else if (buf_write_strobe) begin
            o_buffer_write_enable <= ctl_low; // see [RULE20]
        end
    end

    always @(posedge i_sys_clk) begin
        if (buf_write_strobe && ctl_low) begin
            buf_mem[buf_index] <= buf_wdata; // see [RULE21]
        end
    end

    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_buffer_serial_out <= 1'b0;
        end else begin
            o_buffer_serial_out <= buf_mem[buf_index]; // see [RULE21]
        end
    end

endmodule // fsq_sequencer_core

// *** bench/fsq_far_side_model.sv ***
// Purpose: Far-side model: disk electronics and host serial line
// Assumes: Bench chooses the levels; the model registers them
// Notes:   Levels change only on the system clock edge
module fsq_far_side_model (
    input wire logic i_sys_clk,
    input wire logic i_disk_req,
    input wire logic i_miss_req,
    input wire logic i_serial_req,
    input wire logic [15:0] i_cond_req,
    output logic o_separated_disk_bit = 1'b0,
    output logic o_missing_clock_flag = 1'b0,
    output logic o_interface_serial_data = 1'b0,
    output logic [15:0] o_branch_cond = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge i_sys_clk) begin
        o_separated_disk_bit <= i_disk_req;
        o_missing_clock_flag <= i_miss_req;
        o_interface_serial_data <= i_serial_req;
        o_branch_cond <= i_cond_req;
    end
endmodule // fsq_far_side_model

// *** bench/fsq_sequencer_core_sva.sv ***
// Purpose: Port checks of the sequencer core
// Assumes: Bound to the core, one clock domain
// Notes:   An instruction cycle is four ring steps, 50 clocks
module fsq_core_checker (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_sequencer_init,
    input wire logic o_timing_phase_three,
    input wire logic o_timing_phase_four,
    input wire logic [15:0] o_action_strobe,
    input wire logic o_fetch_load_strobe,
    input wire logic o_wait_branch_count_clock,
    input wire logic [7:0] o_program_counter,
    input wire logic [7:0] o_instruction,
    input wire logic [3:0] o_scratch_addr,
    input wire logic [7:0] o_loop_counter,
    input wire logic o_loop_counter_full
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] hi_len_reg;
    logic [6:0] gap_reg;
    logic p3_old_reg, seen_reg;
    wire p3 = o_timing_phase_three;
    wire rise = p3 && !p3_old_reg;
    wire stb_on = |o_action_strobe;
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn || i_sequencer_init);
    // ---
    // Phase counters
    // ---
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hi_len_reg <= 5'h00;
            gap_reg <= 7'h00;
            p3_old_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            p3_old_reg <= p3;
            hi_len_reg <= p3 ? hi_len_reg + 5'h01 : 5'h00;
            gap_reg <= rise ? 7'h01 : gap_reg + 7'h01;
            seen_reg <= !i_sequencer_init && (seen_reg || rise);
        end
    end
    a_phase_apart: assert property (!(p3 && o_timing_phase_four))
        else $error("phases overlap");
    a_phase_width: assert property ($fell(p3) |-> hi_len_reg inside {5'd12, 5'd13})
        else $error("phase width");
    a_phase_order: assert property ($fell(p3) |-> ##[0:1] o_timing_phase_four)
        else $error("no phase four");
    a_cycle_time: assert property (rise && seen_reg |-> gap_reg == 7'd50)
        else $error("cycle time");
    a_strobe_decode: assert property (stb_on |->
        o_instruction[7:6] == 2'b00 && o_action_strobe == (16'h0001 << o_instruction[5:2]))
        else $error("strobe decode");
    a_strobe_phase: assert property (stb_on |-> p3 || $past(p3))
        else $error("strobe outside phase");
    a_strobe_stand: assert property ($rose(stb_on) |=> stb_on [*8])
        else $error("strobe too short");
    a_fetch_step: assert property (o_fetch_load_strobe |->
        o_program_counter - $past(o_program_counter, 3) == 8'h01)
        else $error("fetch step");
    a_fetch_pulse: assert property (o_fetch_load_strobe |=> !o_fetch_load_strobe [*8])
        else $error("fetch pulse");
    a_wait_clock: assert property (o_wait_branch_count_clock |->
        o_instruction[7:6] == 2'b10 ##1 !o_wait_branch_count_clock)
        else $error("wait clock");
    a_scratch_latch: assert property ($changed(o_scratch_addr) |->
        o_instruction[7:6] == 2'b11 && !o_instruction[1] && o_scratch_addr == o_instruction[5:2])
        else $error("scratch address");
    a_full_flag: assert property ($changed(o_loop_counter) |->
        ##[0:1] o_loop_counter_full == (o_loop_counter == 8'hFF))
        else $error("full flag");
    a_init_pc: assert property (disable iff (!i_rstn) i_sequencer_init [*4] |-> o_program_counter == 8'h00)
        else $error("init pc");
endmodule // fsq_core_checker

// *** bench/fsq_sequencer_core_bench.sv ***
// Purpose: Self-checking bench for the floppy microsequencer core
// Assumes: Field 0 holds the test microprogram
// Notes:   Fetches are traced by word and counter
module fsq_sequencer_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, init = 1'b1, ld_en = 1'b0, d_req = 1'b0, m_req = 1'b0, s_req = 1'b0;
    logic [10:0] ld_addr = 11'h000;
    logic [7:0] ld_data = 8'h00;
    logic [2:0] fsel = 3'h0;
    logic [15:0] c_req = 16'h0000;
    logic sdb, mck, isd, p3, p4, fls, wbc, full, wrap, we, bout, c1;
    logic [15:0] cond, stb;
    logic [7:0] pc, ins, lcnt, shf;
    logic [3:0] sa;
    logic [11:0] ba;
    logic [7:0] prog [0:255];
    logic [31:0] r;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    fsq_sequencer_core u_fsq_sequencer_core (.i_sys_clk(clk), .i_rstn(rstn), .i_sequencer_init(init),
        .i_field_select(fsel), .i_branch_cond(cond), .i_separated_disk_bit(sdb), .i_missing_clock_flag(mck),
        .i_interface_serial_data(isd), .i_rom_load_en(ld_en), .i_rom_load_addr(ld_addr),
        .i_rom_load_data(ld_data), .o_timing_phase_three(p3), .o_timing_phase_four(p4),
        .o_action_strobe(stb), .o_fetch_load_strobe(fls), .o_wait_branch_count_clock(wbc),
        .o_program_counter(pc), .o_instruction(ins), .o_scratch_addr(sa), .o_loop_counter(lcnt),
        .o_loop_counter_full(full), .o_shifter(shf), .o_buffer_addr(ba), .o_buffer_addr_wrap(wrap),
        .o_buffer_write_enable(we), .o_buffer_serial_out(bout));
    fsq_far_side_model u_fsq_far_side_model (.i_sys_clk(clk), .i_disk_req(d_req), .i_miss_req(m_req),
        .i_serial_req(s_req), .i_cond_req(c_req), .o_separated_disk_bit(sdb), .o_missing_clock_flag(mck),
        .o_interface_serial_data(isd), .o_branch_cond(cond));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            test_done();
        end
    end
    // ---
    // Checks
    // ---
    function automatic logic [11:0] buf_base(input logic c0);
        return {~c0, ~c0, 10'h000};
    endfunction
    function automatic logic taken(input logic c, input logic dsk, input logic mis);
        return c == (1'b1 ^ dsk ^ mis);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic exec_wait();
        while (p3 !== 1'b1) @(posedge clk) #1;
        repeat (2) @(posedge clk) #1;
    endtask
    task automatic fetch_chk(input logic [7:0] e_ins, input logic [7:0] e_pc);
        while (fls !== 1'b1) @(posedge clk) #1;
        chk({8'h00, ins}, {8'h00, e_ins});
        chk({8'h00, pc}, {8'h00, e_pc});
        @(posedge clk) #1;
    endtask
    task automatic test_done();
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ---
    // Tests
    // ---
    initial begin
        r = $urandom(38);
        c1 = r[2];
        for (int i = 0; i < 256; i++)
            prog[i] = (i > 0 && i < 9) ? 8'h0A : 8'h00;
        prog[0] = 8'h14;
        prog[9] = 8'h42;
        prog[10] = 8'h20;
        prog[32] = {6'b010001, c1, 1'b0};
        prog[33] = 8'h30;
        prog[34] = 8'hC2;
        prog[35] = 8'h30;
        prog[48] = 8'hA6;
        prog[49] = 8'h40;
        for (int k = 0; k < 16; k++)
            prog[64 + k] = {2'b00, k[3:0], 2'b00};
        prog[80] = 8'hE8;
        prog[81] = 8'h15;
        prog[82] = 8'h16;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        d_req <= r[0];
        m_req <= r[1];
        s_req <= r[3];
        c_req <= r[31:16] & 16'hFDFF;
        @(posedge clk) #1;
        chk({8'h00, pc}, 16'h0000);
        chk(stb, 16'h0000);
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            ld_en <= 1'b1;
            ld_addr <= i[10:0];
            ld_data <= prog[i];
        end
        @(posedge clk);
        ld_en <= 1'b0;
        init <= 1'b0;
        fetch_chk(8'h14, 8'h01);
        exec_wait();
        chk({4'h0, ba}, {4'h0, buf_base(1'b0)});
        for (int i = 1; i < 9; i++)
            fetch_chk(8'h0A, i[7:0] + 8'h01);
        fetch_chk(8'h42, 8'h0A);
        fetch_chk(prog[32], 8'h21);
        if (!taken(c1, r[0], r[1]))
            fetch_chk(8'hC2, 8'h23);
        fetch_chk(8'hA6, 8'h31);
        exec_wait();
        chk({8'h00, lcnt}, 16'h0001);
        fetch_chk(8'hA6, 8'h31);
        @(posedge clk);
        c_req <= c_req | 16'h0200;
        for (int k = 0; k < 16; k++) begin
            fetch_chk({2'b00, k[3:0], 2'b00}, 8'h41 + k[7:0]);
            exec_wait();
            chk(stb, 16'h0001 << k);
            if (k == 1)
                chk({8'h00, lcnt}, {8'h00, prog[66]});
        end
        fetch_chk(8'hE8, 8'h51);
        exec_wait();
        chk({12'h000, sa}, 16'h000A);
        fetch_chk(8'h15, 8'h52);
        exec_wait();
        chk({4'h0, ba}, {4'h0, buf_base(1'b1)});
        fetch_chk(8'h16, 8'h53);
        exec_wait();
        chk({4'h0, ba}, 16'h0001);
        test_done();
    end
endmodule // fsq_sequencer_core_bench

bind fsq_sequencer_core fsq_core_checker u_fsq_core_checker (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_sequencer_init(i_sequencer_init), .o_timing_phase_three(o_timing_phase_three),
    .o_timing_phase_four(o_timing_phase_four), .o_action_strobe(o_action_strobe),
    .o_fetch_load_strobe(o_fetch_load_strobe), .o_wait_branch_count_clock(o_wait_branch_count_clock),
    .o_program_counter(o_program_counter), .o_instruction(o_instruction), .o_scratch_addr(o_scratch_addr),
    .o_loop_counter(o_loop_counter), .o_loop_counter_full(o_loop_counter_full));
